// ---- sea_core.sv ----
// I2C EEPROM slave engine with lock flags, write guard and AXI4-Lite status.
// Assumes an external open-drain bus resolver and a master on SCL and SDA.
`timescale 1ns/1ps
module sea_core
    import sea_pkg::*;
#(
    parameter int unsigned WR_CYCLES = WRITE_CYCLE_US * 1000 / CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              resetn_i,
    // I2C pins and straps
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    input  wire logic [2:0]        addr_pin_i,
    input  wire logic              high_voltage_level_i,
    input  wire logic              write_guard_i,
    // AXI4-Lite write
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    output logic [1:0]             s_axi_bresp_o,
    // AXI4-Lite read
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    input  wire logic [AXI_AW-1:0] s_axi_araddr_i,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o
);
    localparam int unsigned BW = $clog2(WR_CYCLES + 1);

    typedef struct packed {
        sea_state_t       st;
        logic [3:0]       bits;
        logic [7:0]       sh;
        logic             rd;
        logic             lock_cmd;
        logic [1:0]       cmd;
        logic [1:0]       nrx;
        logic             acked;
        logic             mack;
        logic             wg;
        logic [7:0]       ac;
        logic [3:0]       pg;
        logic             wpend;
        logic             fpend;
        logic [15:0]      vld;
        logic             busy;
        logic [BW-1:0]    bcnt;
        logic [4:0]       cidx;
        logic             rev;
        logic             en;
        logic             scl_q;
        logic             sda_q;
        logic             sda_out;
        logic             sda_oe;
        logic             awr;
        logic             awg;
        logic [7:0]       awa;
        logic             wr;
        logic             wgot;
        logic             wd;
        logic             ws;
        logic             bv;
        logic [1:0]       br;
        logic             arr;
        logic             rv;
        logic [31:0]      rdat;
        logic [1:0]       rr;
    } sea_core_t;

    sea_core_t s;
    sea_core_t next_s;
    sea_pins_t sp;
    logic [6:0] sync_q;

    // Array, page buffer and the nonvolatile permanent flag
    logic [7:0] mem [MEM_BYTES] = '{default: ERASED_BYTE};
    logic [7:0] pbuf [PAGE_BYTES];
    logic       perm = 1'b0;

    logic       scl_rise, scl_fall, start_det, stop_det;
    logic       ld, wr_take, perm_set, mem_we, lock_any, hit, ok;
    logic [2:0] eff;
    logic [7:0] cm_addr, tx_byte;

    sea_sync #(.W(7)) u_sync (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .d_i        ({scl_i, sda_i, addr_pin_i, high_voltage_level_i, write_guard_i}),
        .q_o        (sync_q)
    );
    assign sp = sea_pins_t'(sync_q);

    // Bus conditions from synchronised levels
    assign scl_rise  = sp.scl & ~s.scl_q;
    assign scl_fall  = ~sp.scl & s.scl_q;
    assign start_det = sp.scl & s.scl_q & s.sda_q & ~sp.sda;
    assign stop_det  = sp.scl & s.scl_q & ~s.sda_q & sp.sda;
    assign eff       = {sp.pins[2:1], sp.pins[0] | sp.hv};
    assign lock_any  = perm | s.rev;
    assign tx_byte   = mem[s.ac];
    assign cm_addr   = {s.pg, s.cidx[3:0]};
    assign mem_we    = s.busy & ~s.cidx[4] & s.vld[s.cidx[3:0]];

    // Next-state logic
    always_comb begin
        next_s   = s;
        ld       = 1'b0;
        wr_take  = 1'b0;
        perm_set = 1'b0;
        hit      = 1'b0;
        ok       = 1'b0;
        next_s.scl_q   = sp.scl;
        next_s.sda_q   = sp.sda;
        next_s.sda_out = 1'b0;
        // Programming timer and page commit walk
        if (s.busy) begin
            if (!s.cidx[4]) next_s.cidx = s.cidx + 5'h01;
            if (s.bcnt == '0) next_s.busy = 1'b0;
            else next_s.bcnt = s.bcnt - BW'(1);
        end
        if (start_det) begin
            next_s.st     = ST_ADDR;
            next_s.bits   = '0;
            next_s.sda_oe = 1'b0;
            next_s.nrx    = '0;
            next_s.wg     = 1'b0;
            if (!s.busy) begin
                next_s.wpend = 1'b0;
                next_s.fpend = 1'b0;
                next_s.vld   = '0;
            end
        end else if (stop_det) begin
            next_s.st     = ST_IDLE;
            next_s.sda_oe = 1'b0;
            next_s.wpend  = 1'b0;
            next_s.fpend  = 1'b0;
            if ((s.wpend || s.fpend) && !s.busy) begin
                next_s.busy = 1'b1;
                next_s.bcnt = BW'(WR_CYCLES);
                next_s.cidx = '0;
                if (s.fpend) begin
                    perm_set = (s.cmd == CMD_PERM);
                    if (s.cmd == CMD_RSET) next_s.rev = 1'b1;
                    if (s.cmd == CMD_RCLR) next_s.rev = 1'b0;
                end
            end
        end else begin
            unique case (s.st)
                ST_IDLE: begin
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise && s.bits != BYTE_BITS) begin
                        next_s.sh   = {s.sh[6:0], sp.sda};
                        next_s.bits = s.bits + 4'h1;
                    end else if (scl_fall && s.bits == BYTE_BITS && s.st == ST_ADDR) begin
                        next_s.rd = s.sh[0];
                        if (!s.en || s.busy) begin
                            hit = 1'b0;
                        end else if (s.sh[7:4] == PRE_ARRAY && s.sh[3:1] == eff) begin
                            hit = 1'b1;
                            ok  = 1'b1;
                            next_s.lock_cmd = 1'b0;
                        end else if (s.sh[7:4] == PRE_LOCK) begin
                            next_s.lock_cmd = 1'b1;
                            if (!sp.hv) begin
                                hit = 1'b1;
                                ok  = ~perm;
                                next_s.cmd = CMD_PERM;
                            end else if (s.sh[3:1] == eff && eff == RSW_SET_PINS) begin
                                hit = 1'b1;
                                ok  = ~perm & ~s.rev;
                                next_s.cmd = CMD_RSET;
                            end else if (s.sh[3:1] == eff && eff == RSW_CLR_PINS) begin
                                hit = 1'b1;
                                ok  = ~perm;
                                next_s.cmd = CMD_RCLR;
                            end
                        end
                        next_s.st     = hit ? ST_ACKA : ST_IDLE;
                        next_s.sda_oe = hit & ok;
                        next_s.acked  = ok;
                    end else if (scl_fall && s.bits == BYTE_BITS) begin
                        if (s.nrx == 2'h0) begin
                            ok = 1'b1;
                            if (!s.lock_cmd) begin
                                next_s.ac = s.sh;
                                next_s.pg = s.sh[7:4];
                            end
                        end else if (s.lock_cmd) begin
                            ok = ~s.wg;
                            next_s.fpend = ok;
                        end else begin
                            ok = ~s.wg & ~(lock_any & ~s.ac[7]);
                            if (ok) begin
                                wr_take = 1'b1;
                                next_s.vld[s.ac[3:0]] = 1'b1;
                                next_s.ac[3:0] = s.ac[3:0] + 4'h1;
                                next_s.wpend = 1'b1;
                            end
                        end
                        if (s.nrx != 2'h2) next_s.nrx = s.nrx + 2'h1;
                        next_s.st     = ST_ACKR;
                        next_s.sda_oe = ok;
                        next_s.acked  = ok;
                    end
                end
                ST_ACKA: begin
                    if (scl_fall) begin
                        next_s.sda_oe = 1'b0;
                        next_s.bits   = '0;
                        if (!s.acked || (s.rd && s.lock_cmd)) next_s.st = ST_IDLE;
                        else if (s.rd) ld = 1'b1;
                        else next_s.st = ST_RX;
                    end
                end
                ST_ACKR: begin
                    if (scl_fall) begin
                        next_s.sda_oe = 1'b0;
                        next_s.bits   = '0;
                        if (s.nrx == 2'h1) next_s.wg = sp.guard;
                        next_s.st = s.acked ? ST_RX : ST_IDLE;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        next_s.bits = s.bits + 4'h1;
                    end else if (scl_fall && s.bits == BYTE_BITS) begin
                        next_s.sda_oe = 1'b0;
                        next_s.st     = ST_ACKT;
                    end else if (scl_fall) begin
                        next_s.sh     = {s.sh[6:0], 1'b0};
                        next_s.sda_oe = ~s.sh[6];
                    end
                end
                ST_ACKT: begin
                    if (scl_rise) begin
                        next_s.mack = ~sp.sda;
                    end else if (scl_fall) begin
                        ld = s.mack;
                        if (!s.mack) next_s.st = ST_IDLE;
                    end
                end
                default: next_s.st = ST_IDLE;
            endcase
        end
        // Load the next byte to send and step the counter with rollover
        if (ld) begin
            next_s.sh     = tx_byte;
            next_s.ac     = s.ac + 8'h01;
            next_s.bits   = '0;
            next_s.sda_oe = ~tx_byte[7];
            next_s.st     = ST_TX;
        end
        // AXI4-Lite write path
        if (s_axi_awvalid_i && s.awr) begin
            next_s.awg = 1'b1;
            next_s.awa = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s.wr) begin
            next_s.wgot = 1'b1;
            next_s.wd   = s_axi_wdata_i[0];
            next_s.ws   = s_axi_wstrb_i[0];
        end
        if (s.bv && s_axi_bready_i) next_s.bv = 1'b0;
        if (s.awg && s.wgot && !s.bv) begin
            next_s.bv   = 1'b1;
            next_s.awg  = 1'b0;
            next_s.wgot = 1'b0;
            next_s.br   = RESP_OKAY;
            if (s.awa == REG_CTRL) begin
                if (s.ws) next_s.en = s.wd;
            end else if (s.awa != REG_STATUS) begin
                next_s.br = RESP_SLVERR;
            end
        end
        next_s.awr = ~next_s.awg & ~next_s.bv;
        next_s.wr  = ~next_s.wgot & ~next_s.bv;
        // AXI4-Lite read path
        if (s.rv && s_axi_rready_i) next_s.rv = 1'b0;
        if (s_axi_arvalid_i && s.arr) begin
            next_s.rv   = 1'b1;
            next_s.rdat = '0;
            next_s.rr   = RESP_OKAY;
            if (s_axi_araddr_i == REG_CTRL) begin
                next_s.rdat[0] = s.en;
            end else if (s_axi_araddr_i == REG_STATUS) begin
                next_s.rdat[7:0]           = s.ac;
                next_s.rdat[STAT_BUSY_BIT] = s.busy;
                next_s.rdat[STAT_REV_BIT]  = s.rev;
                next_s.rdat[STAT_PERM_BIT] = perm;
                next_s.rdat[STAT_WG_BIT]   = sp.guard;
            end else begin
                next_s.rr = RESP_SLVERR;
            end
        end
        next_s.arr = ~next_s.rv;
    end

    // State register; reversible lock flag starts clear
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s     <= '0;
            s.st  <= ST_IDLE;
            s.en  <= CTRL_EN_RST;
            s.awr <= 1'b1;
            s.wr  <= 1'b1;
            s.arr <= 1'b1;
            s.rev <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // Nonvolatile storage: no reset, permanent flag only ever sets
    always_ff @(posedge core_clk_i) begin
        if (perm_set) perm <= 1'b1;
        if (wr_take) pbuf[s.ac[3:0]] <= s.sh;
        if (mem_we) mem[cm_addr] <= pbuf[s.cidx[3:0]];
    end

    assign sda_o           = s.sda_out;
    assign sda_oe_o        = s.sda_oe;
    assign s_axi_awready_o = s.awr;
    assign s_axi_wready_o  = s.wr;
    assign s_axi_bvalid_o  = s.bv;
    assign s_axi_bresp_o   = s.br;
    assign s_axi_arready_o = s.arr;
    assign s_axi_rvalid_o  = s.rv;
    assign s_axi_rdata_o   = s.rdat;
    assign s_axi_rresp_o   = s.rr;

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    busy_nack_a: assert property (s.busy |-> !s.sda_oe)
        else $error("slave drove SDA while programming");
    stop_start_wr_a: assert property ((stop_det && (s.wpend || s.fpend) && !s.busy)
        |=> (s.busy && s.bcnt == BW'(WR_CYCLES)))
        else $error("STOP did not start programming");
    page_wrap_a: assert property (wr_take |=> (s.ac[7:4] == $past(s.ac[7:4])
        && s.ac[3:0] == $past(s.ac[3:0]) + 4'h1))
        else $error("page pointer left its page");
    read_incr_a: assert property (ld |=> (s.ac == $past(s.ac) + 8'h01 && s.st == ST_TX))
        else $error("read counter did not advance");
    lower_guard_a: assert property (mem_we |-> (cm_addr[7] || !lock_any))
        else $error("write into locked lower half");
    guard_drop_a: assert property ((s.st == ST_ACKR && s.wg) |-> !s.sda_oe)
        else $error("data acked with write guard high");
    flag_read_a: assert property ((s.st == ST_ACKA && s.lock_cmd && s.rd) |->
        (s.sda_oe == !(perm || (s.cmd == CMD_RSET && s.rev))))
        else $error("flag read answer wrong");
    oe_on_fall_a: assert property ($rose(s.sda_oe) |-> $past(scl_fall))
        else $error("SDA driven off a falling SCL");
    perm_keep_a: assert property (perm |=> perm)
        else $error("permanent flag cleared");
    array_ack_a: assert property ((s.st == ST_ACKA && !s.lock_cmd && s.sda_oe) |->
        (s.sh[7:4] == PRE_ARRAY))
        else $error("array ack without matching preamble");

    page_commit_c: cover property (mem_we);
    seq_read_c: cover property (s.st == ST_ACKT && s.mack && scl_fall);
    flag_read_c: cover property (s.st == ST_ACKA && s.lock_cmd && s.rd);
    busy_refuse_c: cover property (s.busy && s.st == ST_ADDR && scl_fall && s.bits == BYTE_BITS);
endmodule // sea_core

// ---- sea_pkg.sv ----
// Constants and carrier types for the serial EEPROM access engine.
// Assumes a 40 MHz core clock, an external I2C master and an AXI4-Lite master.
// Operation
// - Byte write: ack address, offset and data; programming starts at STOP.
// - While programming, the slave address is never acknowledged.
// - 256 bytes as 16 pages of 16; high nibble page, low nibble byte.
// - Page write advances in-page pointer, wrapping inside the page.
// - Delivered with both lock flags clear and every byte reading FFh.
// - Address counter rests one past the last byte, rolling over to zero.
// - Read address is acked in ninth clock, then current byte is sent.
// - Selective read: dummy write loads the counter, repeated START reads.
// - Acknowledged reads continue with successive bytes, wrapping at the end.
// - Any set lock flag refuses writes into the lower 128 bytes.
// - High voltage on pin zero is logic one and enables reversible commands.
// - Upper nibble 0110 selects lock commands, 1010 selects array access.
// - Permanent commands ignore address pins; reversible ones need fixed levels.
// - Lock command LSB one reads, zero sets or clears with dummy bytes.
// - Flag read returns no data: no-ack when set, ack when clear.
// - High write-guard pin blocks all array and flag writes.
// - Guard sampled at last SCL fall before first data byte; high drops it.
// - Array address: 1010, three bits matched to pins, then read bit.
// - SDA captured on SCL rise, changed on SCL fall, open-drain only.
package sea_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned WRITE_CYCLE_US = 5000;
    localparam int unsigned MEM_BYTES      = 256;
    localparam int unsigned PAGE_BYTES     = 16;
    localparam int unsigned AXI_AW         = 8;
    localparam logic [3:0] PRE_ARRAY      = 4'hA;
    localparam logic [3:0] PRE_LOCK       = 4'h6;
    localparam logic [2:0] RSW_SET_PINS   = 3'h1;
    localparam logic [2:0] RSW_CLR_PINS   = 3'h3;
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;
    localparam logic [3:0] BYTE_BITS      = 4'h8;
    localparam logic [1:0] CMD_PERM       = 2'h0;
    localparam logic [1:0] CMD_RSET       = 2'h1;
    localparam logic [1:0] CMD_RCLR       = 2'h2;
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic       CTRL_EN_RST    = 1'b1;
    localparam int unsigned STAT_BUSY_BIT = 8;
    localparam int unsigned STAT_REV_BIT  = 9;
    localparam int unsigned STAT_PERM_BIT = 10;
    localparam int unsigned STAT_WG_BIT   = 11;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ACKA = 7'h04,
        ST_RX   = 7'h08,
        ST_ACKR = 7'h10,
        ST_TX   = 7'h20,
        ST_ACKT = 7'h40
    } sea_state_t;

    // Pins sampled from outside the clock domain
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic [2:0] pins;
        logic       hv;
        logic       guard;
    } sea_pins_t;
endpackage

// ---- sea_sync.sv ----
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes inputs are quasi-static levels; no pulse is narrower than two clocks.
`timescale 1ns/1ps
module sea_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    // Levels
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sea_sync_t;

    sea_sync_t s;
    sea_sync_t next_s;

    // First stage feeds only the second
    always_comb begin
        next_s.s1 = d_i;
        next_s.s2 = s.s1;
    end

    // State register
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.s2;
endmodule // sea_sync

// ---- sea_i2c_mst.sv ----
// I2C bus master model: drives SCL and releases or pulls SDA.
// Assumes the bench resolves SDA with a pull-up.
`timescale 1ns/1ps
module sea_i2c_mst (
    // Bus
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    initial scl_o = 1'b1;
    initial sda_o = 1'b1;
    // START or repeated START
    task automatic start();
        #3 sda_o = 1'b1; // Keeps pin changes off the core clock edges
        #50 scl_o = 1'b1;
        #100 sda_o = 1'b0;
        #100 scl_o = 1'b0;
    endtask
    // STOP ends a frame; the dummy write in sel_rd ends with a repeated START instead
    task automatic stop();
        sda_o = 1'b0;
        #50 scl_o = 1'b1;
        #100 sda_o = 1'b1;
        #100;
    endtask
    // Eight bits MSB first, then ack slot; SDA moves only while SCL low
    task automatic xfer(input logic [7:0] tx, input logic ain, output logic [7:0] rx,
                        output logic ack);
        for (int i = 8; i >= 0; i--) begin
            #25 sda_o = (i == 0) ? ain : tx[i-1];
            #75 scl_o = 1'b1;
            #90 if (i == 0) ack = sda_i; else rx[i-1] = sda_i;
            #10 scl_o = 1'b0;
        end
        #25 sda_o = 1'b1;
    endtask
endmodule // sea_i2c_mst

// ---- tb_top.sv ----
// Bench for the EEPROM engine: I2C master model plus AXI4-Lite tasks.
// Assumes a short write cycle and a pull-up on SDA.
`timescale 1ns/1ps
module tb_top;
    import sea_pkg::*;
    localparam int WRC = 200;
    // Design pins
    logic core_clk_i = 1'b0, resetn_i = 1'b0, high_voltage_level_i = 1'b0, write_guard_i = 1'b0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, scl_i, sda_m, sda_o, sda_oe_o;
    logic [2:0] addr_pin_i = 3'h0;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rv;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs;
    wire sda_i = sda_m & (sda_o | ~sda_oe_o); // Open drain, pull-up
    // Bench state
    int fail_count = 0, n_compared = 0;
    logic [15:0] exq[$], got;
    string nmq[$];
    logic [7:0] rx, d, a, b;
    logic [2:0] aks;
    logic ak;
    event got_ev;
    sea_core #(.WR_CYCLES(WRC)) i_dut (.*);
    sea_i2c_mst i_mst (.scl_o(scl_i), .sda_o(sda_m), .sda_i(sda_i));
    always #12.5 core_clk_i = ~core_clk_i;
    // Record result and expectation
    task automatic note(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        nmq.push_back(nm);
        exq.push_back(exp);
        got = seen;
        ->got_ev;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Monitor takes the oldest expectation
    always @(got_ev) check(got, exq.pop_front(), nmq.pop_front());
    task automatic test_done();
        $display("mismatches %0d compared %0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // AXI write, each channel released when taken
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge core_clk_i);
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        s_axi_awaddr_i <= ad;
        s_axi_wdata_i <= dt;
        do begin
            @(posedge core_clk_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b0;
        rs = s_axi_bresp_o;
    endtask
    // AXI read
    task automatic axi_rd(input logic [7:0] ad);
        @(posedge core_clk_i);
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
        s_axi_araddr_i <= ad;
        do begin
            @(posedge core_clk_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b0;
        rv = s_axi_rdata_o;
        rs = s_axi_rresp_o;
    endtask
    task automatic bt(input logic [7:0] tx, input logic ain);
        i_mst.xfer(tx, ain, rx, ak);
    endtask
    // Three-byte write frame, acks gathered
    task automatic wr(input logic [7:0] sa, input logic [7:0] off, input logic [7:0] dt);
        i_mst.start();
        bt(sa, 1'b1);
        aks[2] = ak;
        bt(off, 1'b1);
        aks[1] = ak;
        bt(dt, 1'b1);
        aks[0] = ak;
        i_mst.stop();
        repeat (WRC + 4) @(posedge core_clk_i);
    endtask
    // Selective read of two bytes
    task automatic sel_rd(input logic [7:0] off, input logic [7:0] e0, input logic [7:0] e1);
        i_mst.start();
        bt(8'hA0, 1'b1);
        bt(off, 1'b1);
        i_mst.start();
        bt(8'hA1, 1'b1);
        aks[0] = ak;
        bt(8'hFF, 1'b0);
        note("first", {7'h0, aks[0], rx}, {8'h0, e0});
        bt(8'hFF, 1'b1);
        note("next", {8'h0, rx}, {8'h0, e1});
        i_mst.stop();
    endtask
    initial begin
        #2_000_000;
        fail_count++;
        test_done();
    end
    // Main sequence
    initial begin
        void'($urandom(96));
        d = 8'($urandom);
        a = 8'($urandom_range(1, 126));
        b = 8'($urandom);
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        axi_rd(REG_STATUS);
        note("flags", {8'h0, rv[15:8]}, 16'h0);
        axi_rd(8'h10);
        note("rresp", {14'h0, rs}, {14'h0, RESP_SLVERR});
        axi_wr(8'h10, 32'h1);
        note("bresp", {14'h0, rs}, {14'h0, RESP_SLVERR});
        axi_wr(REG_CTRL, 32'h0);
        axi_rd(REG_CTRL);
        i_mst.start();
        bt(8'hA0, 1'b1);
        i_mst.stop();
        note("off", {7'h0, ak, 7'h0, rv[0]}, 16'h0100);
        axi_wr(REG_CTRL, 32'h1);
        i_mst.start();
        bt(8'hA0, 1'b1);
        aks[2] = ak;
        bt(a, 1'b1);
        bt(d, 1'b1);
        i_mst.stop();
        i_mst.start();
        bt(8'hA0, 1'b1);
        i_mst.stop();
        note("busy", {aks[2], 7'h0, ak}, 16'h1);
        repeat (WRC) @(posedge core_clk_i);
        write_guard_i <= 1'b1;
        wr(8'hA0, a, ~d);
        note("guard", {13'h0, aks}, 16'h1);
        write_guard_i <= 1'b0;
        sel_rd(a, d, ERASED_BYTE);
        i_mst.start();
        bt(8'hA0, 1'b1);
        bt(8'hFF, 1'b1);
        for (int i = 0; i < 17; i++) bt(b + 8'(i), 1'b1);
        i_mst.stop();
        repeat (WRC) @(posedge core_clk_i);
        sel_rd(8'hFF, b + 8'd16, ERASED_BYTE);
        axi_rd(REG_STATUS);
        note("counter", {8'h0, rv[7:0]}, 16'h1);
        sel_rd(8'hF0, b + 8'd1, b + 8'd2);
        i_mst.start();
        bt(8'hA1, 1'b1);
        bt(8'hFF, 1'b1);
        i_mst.stop();
        note("immediate", {8'h0, rx}, {8'h0, b + 8'd3});
        high_voltage_level_i <= 1'b1;
        addr_pin_i <= 3'h1;
        wr(8'h62, 8'h00, 8'h00);
        i_mst.start();
        bt(8'h63, 1'b1);
        i_mst.stop();
        high_voltage_level_i <= 1'b0;
        addr_pin_i <= 3'h0;
        axi_rd(REG_STATUS);
        note("rev", {aks, 11'h0, ak, rv[STAT_REV_BIT]}, 16'h3);
        wr(8'hA0, 8'h10, d);
        note("low", {13'h0, aks}, 16'h1);
        high_voltage_level_i <= 1'b1;
        addr_pin_i <= 3'h3;
        wr(8'h66, 8'h00, 8'h00);
        high_voltage_level_i <= 1'b0;
        addr_pin_i <= 3'h0;
        axi_rd(REG_STATUS);
        note("clear", {aks, 12'h0, rv[STAT_REV_BIT]}, 16'h0);
        wr(8'h64, 8'h00, 8'h00);
        i_mst.start();
        bt(8'h61, 1'b1);
        i_mst.stop();
        note("perm", {aks, 12'h0, ak}, 16'h1);
        @(posedge core_clk_i) resetn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        axi_rd(REG_STATUS);
        note("keep", {8'h0, rv[15:8]}, 16'h4);
        #1 test_done();
    end
endmodule // tb_top
